// *** hw/tmr_counters.sv ***
// Contract
// RULE1 - timer function advances once per tick, clock divided by one or twelve
// RULE2 - counter function advances once per falling edge on its count pin
// RULE3 - outside source holds each count pin level at least two clocks
// RULE4 - 13-bit mode: high byte holds top eight, low byte bits 4..0 the rest
// RULE5 - 13-bit wrap 1FFF to 0000 sets the overflow flag
// RULE6 - source select bit picks clock ticks (0) or pin edges (1)
// RULE7 - count only when run is 1 and gate is 0 or interrupt pin high
// RULE8 - setting run never loads or clears the count
// RULE9 - timer one behaves like timer zero with its own bytes and bits
// RULE10 - 16-bit mode uses all sixteen bits
// RULE11 - auto-reload: low byte wraps, sets flag, reloads from unchanged high byte
// RULE12 - split mode low byte is timer zero's 8-bit counter/timer
// RULE13 - split mode high byte ticks under timer one run, sets timer one flag
// RULE14 - timer one mode 3 stops and holds timer one
// RULE15 - with timer zero split, timer one uses no pin, no flag, still baud tick
// RULE16 - overflow flags set by hardware, cleared by software or vectoring
// RULE17 - edge mode flag sets on falling edge; level mode flag is inverted input
// RULE18 - type select 0 means level sensing, 1 means falling edge sensing
// RULE19 - timer_control resets to zero at 0x88, bit addressable
// RULE20 - each timer has its own two-bit mode field
// RULE21 - mode field 00/01/10/11; timer one bits 7..4, timer zero bits 3..0
// RULE22 - tick select 0 divides by 12, 1 undivided; timer one bit 4, zero bit 3
// RULE23 - count and gate inputs synchronised; falling edge is high then low
`timescale 1ns/100ps
`default_nettype none
`include "tmr_regs.svh"

module tmr_counters
#(
  parameter int PRESCALE_DIV = `TMR_TICK_DIV
)
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] sfr_addr,
  input  wire logic       sfr_wr,
  input  wire logic [7:0] sfr_wdata,
  input  wire logic       sfr_rd,
  output logic      [7:0] sfr_rdata,
  input  wire logic       sfr_bit_wr,
  input  wire logic [7:0] sfr_bit_addr,
  input  wire logic       sfr_bit_val,
  input  wire logic       vec_t_zero,
  input  wire logic       vec_t_one,
  input  wire logic       vec_ext_zero,
  input  wire logic       vec_ext_one,
  input  wire logic       count_pin_zero,
  input  wire logic       count_pin_one,
  input  wire logic       ext_irq_zero_n,
  input  wire logic       ext_irq_one_n,
  output logic            t_zero_overflow_flag,
  output logic            t_one_overflow_flag,
  output logic            ext_irq_zero_flag,
  output logic            ext_irq_one_flag,
  output logic            baud_tick
);

  generate
    if (PRESCALE_DIV < 2 || PRESCALE_DIV > 16)
    begin : g_bad_div
      $error("tmr_counters: PRESCALE_DIV must lie in 2..16");
    end
  endgenerate

  logic [7:0] t_zero_low_byte;
  logic [7:0] t_zero_high_byte;
  logic [7:0] t_one_low_byte;
  logic [7:0] t_one_high_byte;
  logic [7:0] timer_mode_select;
  logic [1:0] tick_select_bits;
  logic       t_zero_run;
  logic       t_one_run;
  logic       ext_irq_zero_type;
  logic       ext_irq_one_type;
  logic [3:0] pre_cnt;
  logic       tick_slow;
  logic       tick_zero;
  logic       tick_one;
  logic       pin0_fall;
  logic       pin1_fall;
  logic       irq0_lvl;
  logic       irq0_fall;
  logic       irq1_lvl;
  logic       irq1_fall;
  logic       t_zero_gate_enable;
  logic       t_one_gate_enable;
  logic       t_zero_source_select;
  logic       t_one_source_select;
  tmr_pkg::tmr_mode_t mode_zero;
  tmr_pkg::tmr_mode_t mode_one;
  logic       split;
  logic       en_zero;
  logic       en_one;
  logic       inc_zero;
  logic       inc_one;
  logic       inc_high_zero;
  logic [16:0] step_zero;
  logic [16:0] step_one;
  logic       ovf_zero;
  logic       ovf_one;
  logic       ovf_high_zero;
  logic       ctrl_wr;
  logic       ctrl_bit_wr;
  logic       no_wr;
  logic [7:0] timer_control;
  logic [7:0] sw_ctrl;

  // mode fields: timer one in bits 7..4, timer zero in bits 3..0 [RULE20] [RULE21]
  assign t_one_gate_enable    = timer_mode_select[7];
  assign t_one_source_select  = timer_mode_select[6];
  assign mode_one             = tmr_pkg::tmr_mode_t'(timer_mode_select[5:4]);
  assign t_zero_gate_enable   = timer_mode_select[3];
  assign t_zero_source_select = timer_mode_select[2];
  assign mode_zero            = tmr_pkg::tmr_mode_t'(timer_mode_select[1:0]);
  assign split                = (mode_zero == tmr_pkg::TMR_MODE_SPLIT);

  // pin synchronisers; idle high so no false edge leaves reset [RULE23]
  tmr_pin_sync u_sync_c0 (.clk(clk), .rst_n(rst_n), .pin_in(count_pin_zero),
                          .level(), .fall(pin0_fall));
  tmr_pin_sync u_sync_c1 (.clk(clk), .rst_n(rst_n), .pin_in(count_pin_one),
                          .level(), .fall(pin1_fall));
  tmr_pin_sync u_sync_i0 (.clk(clk), .rst_n(rst_n), .pin_in(ext_irq_zero_n),
                          .level(irq0_lvl), .fall(irq0_fall));
  tmr_pin_sync u_sync_i1 (.clk(clk), .rst_n(rst_n), .pin_in(ext_irq_one_n),
                          .level(irq1_lvl), .fall(irq1_fall));

  // free-running divide-by-twelve prescaler shared by both timers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pre_cnt <= 4'h0;
    else if (tick_slow)
      pre_cnt <= 4'h0;
    else
      pre_cnt <= pre_cnt + 4'h1;
  end

  assign tick_slow = (pre_cnt == 4'(PRESCALE_DIV - 1));
  // tick select: 0 slow tick, 1 every clock [RULE1] [RULE22]
  assign tick_zero = tick_select_bits[0] | tick_slow;
  assign tick_one  = tick_select_bits[1] | tick_slow;

  // run and gate; gate needs the interrupt pin high [RULE7]
  assign en_zero = t_zero_run & (~t_zero_gate_enable | irq0_lvl);
  assign en_one  = t_one_run & (~t_one_gate_enable | irq1_lvl);
  // source select picks ticks or pin edges [RULE6] [RULE2]
  assign inc_zero = en_zero & (t_zero_source_select ? pin0_fall : tick_zero);
  // timer one loses its pin while zero is split, halts in mode 3 [RULE15] [RULE14]
  assign inc_one = en_one & (mode_one != tmr_pkg::TMR_MODE_SPLIT)
                 & ((t_one_source_select & ~split) ? pin1_fall : tick_one);
  // split high byte: ticks only, under timer one run [RULE13]
  assign inc_high_zero = split & t_one_run & tick_zero;

  // one count step; returns {wrap, high, low}
  function automatic logic [16:0] tmr_step(input tmr_pkg::tmr_mode_t mode,
                                           input logic [7:0] lo,
                                           input logic [7:0] hi);
    logic [12:0] c13;
    logic [15:0] c16;
    logic [16:0] r;
    c13 = {hi, lo[4:0]} + 13'h0001;
    c16 = {hi, lo} + 16'h0001;
    case (mode)
      // low bits 7..5 untouched, only 4..0 count [RULE4] [RULE5]
      tmr_pkg::TMR_MODE_13BIT:  r = {&{hi, lo[4:0]}, c13[12:5], lo[7:5], c13[4:0]};
      tmr_pkg::TMR_MODE_16BIT:  r = {&{hi, lo}, c16}; // [RULE10]
      // reload low from high, high kept [RULE11]
      tmr_pkg::TMR_MODE_RELOAD8: r = (&lo) ? {1'b1, hi, hi} : {1'b0, hi, lo + 8'h01};
      default:                  r = {&lo, hi, lo + 8'h01}; // [RULE12]
    endcase
    return r;
  endfunction : tmr_step

  // both timers share one step function [RULE9]
  assign step_zero     = tmr_step(mode_zero, t_zero_low_byte, t_zero_high_byte);
  assign step_one      = tmr_step(mode_one, t_one_low_byte, t_one_high_byte);
  assign ovf_zero      = inc_zero & step_zero[16];
  assign ovf_one       = inc_one & step_one[16];
  assign ovf_high_zero = inc_high_zero & (&t_zero_high_byte);

  // timer zero count bytes; a bus write to a byte beats counting [RULE8]
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      t_zero_low_byte  <= `TMR_RST_BYTE;
      t_zero_high_byte <= `TMR_RST_BYTE;
    end
    else
    begin
      if (sfr_wr && sfr_addr == `TMR_ADDR_LOW0)
        t_zero_low_byte <= sfr_wdata;
      else if (inc_zero)
        t_zero_low_byte <= step_zero[7:0];
      if (sfr_wr && sfr_addr == `TMR_ADDR_HIGH0)
        t_zero_high_byte <= sfr_wdata;
      else if (split)
      begin
        if (inc_high_zero)
          t_zero_high_byte <= t_zero_high_byte + 8'h01; // [RULE13]
      end
      else if (inc_zero)
        t_zero_high_byte <= step_zero[15:8];
    end
  end

  // timer one count bytes [RULE9]
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      t_one_low_byte  <= `TMR_RST_BYTE;
      t_one_high_byte <= `TMR_RST_BYTE;
    end
    else
    begin
      if (sfr_wr && sfr_addr == `TMR_ADDR_LOW1)
        t_one_low_byte <= sfr_wdata;
      else if (inc_one)
        t_one_low_byte <= step_one[7:0];
      if (sfr_wr && sfr_addr == `TMR_ADDR_HIGH1)
        t_one_high_byte <= sfr_wdata;
      else if (inc_one)
        t_one_high_byte <= step_one[15:8];
    end
  end

  // mode and tick select registers; unlisted tick bits are not stored
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_mode_select <= `TMR_RST_BYTE;
      tick_select_bits  <= 2'h0;
    end
    else
    begin
      if (sfr_wr && sfr_addr == `TMR_ADDR_MODE)
        timer_mode_select <= sfr_wdata;
      if (sfr_wr && sfr_addr == `TMR_ADDR_TICK)
        tick_select_bits <= {sfr_wdata[`TMR_TICK_SEL1], sfr_wdata[`TMR_TICK_SEL0]}; // [RULE22]
    end
  end

  // software view of timer_control, byte or single-bit write [RULE19]
  assign timer_control = {t_one_overflow_flag, t_one_run, t_zero_overflow_flag, t_zero_run,
                          ext_irq_one_flag, ext_irq_one_type, ext_irq_zero_flag,
                          ext_irq_zero_type};
  assign ctrl_wr     = sfr_wr && sfr_addr == `TMR_ADDR_CTRL;
  assign ctrl_bit_wr = sfr_bit_wr && sfr_bit_addr[7:3] == `TMR_BITBASE_CTRL;
  assign no_wr       = ~sfr_wr & ~sfr_bit_wr;

  always_comb
  begin
    sw_ctrl = timer_control;
    if (ctrl_wr)
      sw_ctrl = sfr_wdata;
    else if (ctrl_bit_wr)
      sw_ctrl[sfr_bit_addr[2:0]] = sfr_bit_val;
  end

  // run and type bits: plain software bits, reset to zero [RULE19] [RULE18]
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      t_zero_run        <= 1'b0;
      t_one_run         <= 1'b0;
      ext_irq_zero_type <= 1'b0;
      ext_irq_one_type  <= 1'b0;
    end
    else
    begin
      t_zero_run        <= sw_ctrl[`TMR_CTRL_RUN0];
      t_one_run         <= sw_ctrl[`TMR_CTRL_RUN1];
      ext_irq_zero_type <= sw_ctrl[`TMR_CTRL_ETYP0];
      ext_irq_one_type  <= sw_ctrl[`TMR_CTRL_ETYP1];
    end
  end

  // overflow flags: hardware set beats software or vector clear [RULE16]
  // split mode hands timer one's flag to the high byte of zero [RULE13] [RULE15]
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      t_zero_overflow_flag <= 1'b0;
      t_one_overflow_flag  <= 1'b0;
    end
    else
    begin
      t_zero_overflow_flag <= ovf_zero | (sw_ctrl[`TMR_CTRL_OVF0] & ~vec_t_zero);
      t_one_overflow_flag  <= (split ? ovf_high_zero : ovf_one)
                            | (sw_ctrl[`TMR_CTRL_OVF1] & ~vec_t_one);
    end
  end

  // external interrupt flags: edge sticky, level follows the inverted pin [RULE17] [RULE18]
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_irq_zero_flag <= 1'b0;
      ext_irq_one_flag  <= 1'b0;
    end
    else
    begin
      if (ext_irq_zero_type)
        ext_irq_zero_flag <= irq0_fall | (sw_ctrl[`TMR_CTRL_EFLG0] & ~vec_ext_zero);
      else
        ext_irq_zero_flag <= ~irq0_lvl;
      if (ext_irq_one_type)
        ext_irq_one_flag <= irq1_fall | (sw_ctrl[`TMR_CTRL_EFLG1] & ~vec_ext_one);
      else
        ext_irq_one_flag <= ~irq1_lvl;
    end
  end

  // timer one overflow still feeds the baud tick in split mode [RULE15]
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      baud_tick <= 1'b0;
    else
      baud_tick <= ovf_one;
  end

  // registered read; unmapped addresses read zero
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sfr_rdata <= `TMR_RST_BYTE;
    else if (sfr_rd)
    begin
      case (sfr_addr)
        `TMR_ADDR_CTRL:  sfr_rdata <= timer_control;
        `TMR_ADDR_MODE:  sfr_rdata <= timer_mode_select;
        `TMR_ADDR_LOW0:  sfr_rdata <= t_zero_low_byte;
        `TMR_ADDR_LOW1:  sfr_rdata <= t_one_low_byte;
        `TMR_ADDR_HIGH0: sfr_rdata <= t_zero_high_byte;
        `TMR_ADDR_HIGH1: sfr_rdata <= t_one_high_byte;
        `TMR_ADDR_TICK:  sfr_rdata <= {3'h0, tick_select_bits, 3'h0};
        default:         sfr_rdata <= 8'h00;
      endcase
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence seq_wrap13;
    inc_zero && no_wr && mode_zero == tmr_pkg::TMR_MODE_13BIT
      && {t_zero_high_byte, t_zero_low_byte[4:0]} == 13'h1FFF;
  endsequence

  sequence seq_reload8;
    inc_zero && no_wr && mode_zero == tmr_pkg::TMR_MODE_RELOAD8 && t_zero_low_byte == 8'hFF;
  endsequence

  sequence seq_split_high_wrap;
    split && inc_high_zero && t_zero_high_byte == 8'hFF;
  endsequence

  AST_PRESCALE: assert property (tick_slow |-> ##12 tick_slow) // [RULE1]
    else $error("slow tick period wrong");

  AST_STOPPED: assert property ((!t_zero_run && !split && no_wr) |=> // [RULE7]
      $stable({t_zero_high_byte, t_zero_low_byte}))
    else $error("timer zero moved while stopped");

  AST_GATED: assert property ((t_zero_gate_enable && !irq0_lvl) |-> !inc_zero) // [RULE7]
    else $error("timer zero counted with gate low");

  AST_T1_HALT: assert property ((mode_one == tmr_pkg::TMR_MODE_SPLIT && no_wr) |=> // [RULE14]
      $stable({t_one_high_byte, t_one_low_byte}))
    else $error("timer one moved in mode 3");

  AST_WRAP13: assert property (seq_wrap13 |=> t_zero_overflow_flag // [RULE5]
      && t_zero_high_byte == 8'h00 && t_zero_low_byte[4:0] == 5'h00)
    else $error("13-bit wrap wrong");

  AST_RELOAD: assert property (seq_reload8 |=> t_zero_overflow_flag // [RULE11]
      && t_zero_low_byte == $past(t_zero_high_byte) && $stable(t_zero_high_byte))
    else $error("auto-reload wrong");

  AST_EDGE_COUNT: assert property ((t_zero_source_select && en_zero && pin0_fall // [RULE2]
      && no_wr && mode_zero == tmr_pkg::TMR_MODE_16BIT) |=>
      {t_zero_high_byte, t_zero_low_byte} == $past({t_zero_high_byte, t_zero_low_byte})
      + 16'h0001)
    else $error("edge not counted");

  AST_VEC_CLR: assert property ((vec_t_zero && !ovf_zero && no_wr) |=> // [RULE16]
      !t_zero_overflow_flag)
    else $error("vector did not clear flag");

  AST_LEVEL_FLAG: assert property (!ext_irq_zero_type |=> // [RULE17]
      ext_irq_zero_flag == !$past(irq0_lvl))
    else $error("level flag does not follow pin");

  AST_SPLIT_TF1: assert property (seq_split_high_wrap |=> t_one_overflow_flag) // [RULE13]
    else $error("split high byte did not set timer one flag");

  AST_SPLIT_NO_TF1: assert property ((split && !ovf_high_zero && !t_one_overflow_flag // [RULE15]
      && no_wr) |=> !t_one_overflow_flag)
    else $error("timer one flag set while zero split");

endmodule : tmr_counters

`default_nettype wire

// *** hw/tmr_pin_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

module tmr_pin_sync
(
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin_in,
  output logic      level,
  output logic      fall
);

  logic s1;
  logic s2;
  logic s3;

  // three stages; s1 feeds only s2 to keep metastability contained
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
    end
    else
    begin
      s1 <= pin_in;
      s2 <= s1;
      s3 <= s2;
    end
  end

  // accept a new level only when the last two stages agree
  // sources hold each level two cycles, so agreement is always reached [RULE3]
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      level <= 1'b1;
      fall  <= 1'b0;
    end
    else
    begin
      fall <= 1'b0;
      if (s2 == s3 && s3 != level)
      begin
        level <= s3;
        fall  <= level & ~s3; // sampled high then sampled low [RULE23]
      end
    end
  end

endmodule : tmr_pin_sync

`default_nettype wire

// *** hw/tmr_pkg.sv ***
package tmr_pkg;

  // mode_field encoding, in order 00..11
  typedef enum logic [1:0] {
    TMR_MODE_13BIT,
    TMR_MODE_16BIT,
    TMR_MODE_RELOAD8,
    TMR_MODE_SPLIT
  } tmr_mode_t;

endpackage : tmr_pkg

// *** hw/tmr_regs.svh ***
`ifndef TMR_REGS_SVH
`define TMR_REGS_SVH

// register bus addresses
`define TMR_ADDR_CTRL      8'h88
`define TMR_ADDR_MODE      8'h89
`define TMR_ADDR_LOW0      8'h8A
`define TMR_ADDR_LOW1      8'h8B
`define TMR_ADDR_HIGH0     8'h8C
`define TMR_ADDR_HIGH1     8'h8D
`define TMR_ADDR_TICK      8'h8E
// bit address base of timer_control (bit addresses 0x88..0x8F)
`define TMR_BITBASE_CTRL   5'h11

// timer_control field positions
`define TMR_CTRL_OVF1      7
`define TMR_CTRL_RUN1      6
`define TMR_CTRL_OVF0      5
`define TMR_CTRL_RUN0      4
`define TMR_CTRL_EFLG1     3
`define TMR_CTRL_ETYP1     2
`define TMR_CTRL_EFLG0     1
`define TMR_CTRL_ETYP0     0

// tick_divide_control field positions
`define TMR_TICK_SEL1      4
`define TMR_TICK_SEL0      3

// reset values
`define TMR_RST_BYTE       8'h00

// slow tick divides the system clock by this count
`define TMR_TICK_DIV       12

`endif

// *** sim/timer0_timer1_counters_tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module timer0_timer1_counters_tb_top;
  typedef struct {string nm; logic [7:0] v; logic [7:0] m;} tmr_note_t;
  logic       clk, rst_n, sfr_wr, sfr_rd, sfr_bit_wr, sfr_bit_val;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, sfr_bit_addr, r;
  logic       vec_t_zero, vec_t_one, vec_ext_zero, vec_ext_one;
  logic       count_pin_zero, count_pin_one, ext_irq_zero_n, ext_irq_one_n;
  logic       t_zero_overflow_flag, t_one_overflow_flag, baud_tick;
  logic       ext_irq_zero_flag, ext_irq_one_flag;
  tmr_note_t  notes[$];
  tmr_note_t  note;
  int         n_mismatch, comparisons, cycles, n_baud;

  tmr_counters #(.PRESCALE_DIV(12)) dut (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
    .sfr_bit_wr(sfr_bit_wr), .sfr_bit_addr(sfr_bit_addr), .sfr_bit_val(sfr_bit_val),
    .vec_t_zero(vec_t_zero), .vec_t_one(vec_t_one), .vec_ext_zero(vec_ext_zero),
    .vec_ext_one(vec_ext_one), .count_pin_zero(count_pin_zero),
    .count_pin_one(count_pin_one), .ext_irq_zero_n(ext_irq_zero_n),
    .ext_irq_one_n(ext_irq_one_n), .t_zero_overflow_flag(t_zero_overflow_flag),
    .t_one_overflow_flag(t_one_overflow_flag), .ext_irq_zero_flag(ext_irq_zero_flag),
    .ext_irq_one_flag(ext_irq_one_flag), .baud_tick(baud_tick));

  tmr_cpu_model cpu (.clk(clk), .sfr_rdata(sfr_rdata), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_bit_wr(sfr_bit_wr),
    .sfr_bit_addr(sfr_bit_addr), .sfr_bit_val(sfr_bit_val), .vec_t_zero(vec_t_zero),
    .vec_t_one(vec_t_one), .vec_ext_zero(vec_ext_zero), .vec_ext_one(vec_ext_one));

  // free-running system clock
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  task automatic stop_test();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
    begin
      $display("SIMULATION PASSED");
    end
    else
    begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  // hang guard, far beyond the few hundred cycles the sequence needs
  always @(posedge clk)
  begin
    cycles++;
    // a baud pulse stands one cycle, so each is counted once
    if (baud_tick === 1'h1) n_baud++;
    if (cycles == 20000)
    begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic check_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : check_byte

  task automatic check_bit(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : check_bit

  // read data lands on the taking edge itself; oldest note is the match
  always @(posedge clk)
  begin
    if (sfr_rd === 1'h1)
    begin
      #2;
      note = notes.pop_front();
      check_byte(note.nm, note.v & note.m, sfr_rdata & note.m);
    end
  end

  task automatic read_exp(input logic [7:0] a, input logic [7:0] v, input logic [7:0] m = 8'hFF);
    notes.push_back('{$sformatf("register %h", a), v, m});
    cpu.rd(a);
  endtask : read_exp

  task automatic wait_cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : wait_cycles

  // run bit high for exactly n counting edges (n >= 2)
  task automatic run(input logic [7:0] ba, input int n);
    cpu.bwr(ba, 1'h1);
    repeat (n - 2) @(posedge clk);
    cpu.bwr(ba, 1'h0);
  endtask : run

  // low and high each three clocks keeps the rate below a quarter of the clock
  task automatic pin_edges(input int n);
    repeat (n)
    begin
      wait_cycles(1);
      count_pin_zero = 1'h0;
      wait_cycles(3);
      count_pin_zero = 1'h1;
      wait_cycles(2);
    end
  endtask : pin_edges

  // main sequence: reset, registers, then scenarios for every mode, the pins, the gate and interrupts
  initial
  begin
    rst_n = 1'h0;
    {count_pin_zero, count_pin_one, ext_irq_zero_n, ext_irq_one_n} = 4'hF;
    void'($urandom(1136));
    r = 8'($urandom());
    wait_cycles(3);
    rst_n = 1'h1;
    for (int a = 8'h88; a <= 8'h8E; a++) read_exp(8'(a), 8'h00);
    cpu.wr(8'h90, 8'hA5);
    read_exp(8'h90, 8'h00);
    cpu.wr(8'h89, r);
    read_exp(8'h89, r);
    cpu.wr(8'h8E, 8'hFF);
    read_exp(8'h8E, 8'h18);
    // 16-bit timer zero, undivided ticks, wraps through all ones
    cpu.wr(8'h89, 8'h11);
    cpu.wr(8'h8A, 8'hF0);
    cpu.wr(8'h8C, 8'hFF);
    run(8'h8C, 20);
    read_exp(8'h8A, 8'h04);
    read_exp(8'h8C, 8'h00);
    read_exp(8'h88, 8'h20);
    cpu.vec(0);
    wait_cycles(2);
    check_bit("t_zero_overflow_flag", 1'h0, t_zero_overflow_flag);
    // 13-bit timer one wraps 1FFF to 0000
    cpu.wr(8'h89, 8'h00);
    cpu.wr(8'h8B, 8'h1E);
    cpu.wr(8'h8D, 8'hFF);
    run(8'h8E, 3);
    read_exp(8'h8B, 8'h01, 8'h1F);
    read_exp(8'h8D, 8'h00);
    check_bit("t_one_overflow_flag", 1'h1, t_one_overflow_flag);
    check_byte("baud_tick count", 8'h01, 8'(n_baud));
    cpu.vec(1);
    wait_cycles(2);
    check_bit("t_one_overflow_flag", 1'h0, t_one_overflow_flag);
    // auto-reload on divide-by-12 ticks: 60 clocks give exactly 5 ticks
    cpu.wr(8'h8E, 8'h00);
    cpu.wr(8'h89, 8'h02);
    cpu.wr(8'h8C, 8'hFE);
    cpu.wr(8'h8A, 8'hFD);
    run(8'h8C, 60);
    read_exp(8'h8A, 8'hFE);
    read_exp(8'h8C, 8'hFE);
    read_exp(8'h88, 8'h20);
    cpu.wr(8'h88, 8'h00);
    // counter function: three falling edges, clock ticks would give far more
    cpu.wr(8'h8E, 8'h18);
    cpu.wr(8'h89, 8'h05);
    cpu.wr(8'h8A, 8'h00);
    cpu.bwr(8'h8C, 1'h1);
    pin_edges(3);
    wait_cycles(8);
    cpu.bwr(8'h8C, 1'h0);
    read_exp(8'h8A, 8'h03);
    // gate: low interrupt pin stops, high lets it count
    cpu.wr(8'h89, 8'h09);
    cpu.wr(8'h8A, 8'h00);
    ext_irq_zero_n = 1'h0;
    wait_cycles(6); // let the synchronised gate fall before the run bit rises
    run(8'h8C, 24);
    read_exp(8'h8A, 8'h00);
    check_bit("ext_irq_zero_flag", 1'h1, ext_irq_zero_flag);
    ext_irq_zero_n = 1'h1;
    wait_cycles(6);
    run(8'h8C, 30);
    read_exp(8'h8A, 8'h1E);
    check_bit("ext_irq_zero_flag", 1'h0, ext_irq_zero_flag);
    // edge-sensed external interrupt one, cleared by vectoring
    cpu.bwr(8'h8A, 1'h1);
    ext_irq_one_n = 1'h0;
    wait_cycles(3);
    ext_irq_one_n = 1'h1;
    wait_cycles(6);
    check_bit("ext_irq_one_flag", 1'h1, ext_irq_one_flag);
    read_exp(8'h88, 8'h0C);
    cpu.vec(3);
    wait_cycles(2);
    check_bit("ext_irq_one_flag", 1'h0, ext_irq_one_flag);
    cpu.wr(8'h88, 8'h00);
    // split mode: high byte under timer one run sets timer one flag
    // timer one asks for pin edges but must count ticks and wrap without its flag
    cpu.wr(8'h89, 8'h43);
    cpu.wr(8'h8A, 8'h55);
    cpu.wr(8'h8C, 8'hFE);
    cpu.wr(8'h8B, 8'h1F);
    cpu.wr(8'h8D, 8'hFF);
    run(8'h8E, 3);
    read_exp(8'h8C, 8'h01);
    read_exp(8'h8A, 8'h55);
    read_exp(8'h8B, 8'h02, 8'h1F);
    read_exp(8'h88, 8'h80);
    check_byte("baud_tick count", 8'h02, 8'(n_baud));
    // timer one mode 3 holds its value while running
    cpu.wr(8'h89, 8'h30);
    cpu.wr(8'h8B, 8'h12);
    cpu.wr(8'h8D, 8'h34);
    run(8'h8E, 20);
    read_exp(8'h8B, 8'h12);
    read_exp(8'h8D, 8'h34);
    wait_cycles(4);
    stop_test();
  end
endmodule : timer0_timer1_counters_tb_top
`default_nettype wire

// *** sim/tmr_cpu_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// stands in for the cpu core on the special function register bus
module tmr_cpu_model
(
  input  wire logic       clk,
  input  wire logic [7:0] sfr_rdata,
  output logic      [7:0] sfr_addr,
  output logic            sfr_wr,
  output logic      [7:0] sfr_wdata,
  output logic            sfr_rd,
  output logic            sfr_bit_wr,
  output logic      [7:0] sfr_bit_addr,
  output logic            sfr_bit_val,
  output logic            vec_t_zero,
  output logic            vec_t_one,
  output logic            vec_ext_zero,
  output logic            vec_ext_one
);
  // bus idle at time zero
  initial
  begin
    {sfr_addr, sfr_wr, sfr_wdata, sfr_rd} = '0;
    {sfr_bit_wr, sfr_bit_addr, sfr_bit_val} = '0;
    {vec_t_zero, vec_t_one, vec_ext_zero, vec_ext_one} = '0;
  end

  // each request is raised after an edge and held until the edge that takes it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'h1;
    @(posedge clk);
    #1;
    sfr_wr = 1'h0;
    sfr_wdata = ~d; // stale data never looks like a fresh write
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    #1;
    sfr_addr = a;
    sfr_rd = 1'h1;
    @(posedge clk);
    #1;
    sfr_rd = 1'h0;
  endtask : rd

  task automatic bwr(input logic [7:0] a, input logic v);
    @(posedge clk);
    #1;
    sfr_bit_addr = a;
    sfr_bit_val = v;
    sfr_bit_wr = 1'h1;
    @(posedge clk);
    #1;
    sfr_bit_wr = 1'h0;
    sfr_bit_val = ~v;
  endtask : bwr

  // one-cycle vectoring pulse: 0 timer zero, 1 timer one, 2 and 3 external
  task automatic vec(input int k);
    @(posedge clk);
    #1;
    {vec_ext_one, vec_ext_zero, vec_t_one, vec_t_zero} = 4'h1 << k;
    @(posedge clk);
    #1;
    {vec_ext_one, vec_ext_zero, vec_t_one, vec_t_zero} = 4'h0;
  endtask : vec
endmodule : tmr_cpu_model
`default_nettype wire
